// File: hw/tmr_alarm.sv
// Purpose: fault queue and comparator or interrupt alarm state
// Assumes: reset already synchronised by the caller
// Notes:   alarm_active is the logical state; polarity is applied outside
`default_nettype none
module tmr_alarm import tmr_pkg::*; (
	// clock, reset, enable
	input  wire logic  i_ref_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_clk_en,
	// filter side of the carrier
	tmr_alarm_if.flt   al
);
	logic [2:0] hot_cnt_r;
	logic [2:0] cold_cnt_r;
	logic       active_r;
	logic       shdn_d_r;
	logic       active_nxt;

	wire        take      = al.conv_valid & ~al.shutdown;             // [RQ14]
	wire        hot       = $signed(al.temp) > $signed(al.alm_thr);    // [RQ11]
	wire        cold      = $signed(al.temp) < $signed(al.rel_thr);    // [RQ11]
	wire  [2:0] need      = tmr_queue_depth(al.queue_sel);             // [RQ7]
	wire  [2:0] hot_nxt   = !hot ? 3'h0 : (hot_cnt_r == QMAX) ? QMAX : hot_cnt_r + 3'h1;
	wire  [2:0] cold_nxt  = !cold ? 3'h0 : (cold_cnt_r == QMAX) ? QMAX : cold_cnt_r + 3'h1;
	wire        hot_q     = take & hot & (hot_nxt >= need);             // [RQ7]
	wire        cold_q    = take & cold & (cold_nxt >= need);           // [RQ7]
	wire        shdn_rise = al.shutdown & ~shdn_d_r;

	// set wins over the read clear so an event on the clearing cycle survives
	always_comb begin
		active_nxt = active_r;
		if (al.mode_int) begin                                          // [RQ5]
			if (hot_q) active_nxt = 1'b1;
			else if (al.read_clr | shdn_rise) active_nxt = 1'b0;       // [RQ13] [RQ14]
		end else begin
			if (hot_q) active_nxt = 1'b1;                               // [RQ12]
			else if (cold_q) active_nxt = 1'b0;                         // [RQ12] [RQ15]
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hot_cnt_r  <= 3'h0;
			cold_cnt_r <= 3'h0;
			active_r   <= 1'b0;
			shdn_d_r   <= 1'b0;
		end else if (i_clk_en) begin
			if (take) hot_cnt_r <= hot_nxt;
			if (take) cold_cnt_r <= cold_nxt;
			active_r <= active_nxt;
			shdn_d_r <= al.shutdown;
		end
	end

	assign al.alarm_active = active_r;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	a_hot_sets:     assert property (i_clk_en && hot_q |=> active_r) // [RQ12]
		else $error("qualified hot result did not raise alarm");
	a_cold_clears:  assert property (i_clk_en && !al.mode_int && cold_q && !hot_q // [RQ12]
		|=> !active_r)
		else $error("comparator alarm not released on cold result");
	a_read_clears:  assert property (i_clk_en && al.mode_int && al.read_clr && !hot_q // [RQ13]
		|=> !active_r)
		else $error("interrupt alarm not cleared by read");
	a_shdn_clears:  assert property (i_clk_en && al.mode_int && shdn_rise && !hot_q // [RQ14]
		|=> !active_r)
		else $error("shutdown entry did not clear interrupt alarm");
	a_shdn_holds:   assert property (i_clk_en && !al.mode_int && al.shutdown // [RQ15]
		|=> $stable(active_r))
		else $error("comparator alarm moved during shutdown");
	a_queue_gate:   assert property (i_clk_en && !active_r && !hot_q |=> !active_r) // [RQ7]
		else $error("alarm rose without a qualified result");
	a_signed_cmp:   assert property (al.temp == 9'h1ff && al.alm_thr == 9'h000 |-> !hot) // [RQ11]
		else $error("signed comparison treated negative as hot");

	c_queue_six:    cover property (hot_q && need == QMAX);
	c_int_cleared:  cover property (al.mode_int && active_r ##1 !active_r);
endmodule // tmr_alarm
`default_nettype wire

// File: hw/tmr_alarm_if.sv
// Purpose: carrier between register logic and the alarm filter
// Assumes: all signals on the system clock
// Notes:   read_clr is a one-cycle pulse
`default_nettype none
interface tmr_alarm_if;
	logic       conv_valid;
	logic [8:0] temp;
	logic [8:0] alm_thr;
	logic [8:0] rel_thr;
	logic       mode_int;
	logic       shutdown;
	logic [1:0] queue_sel;
	logic       read_clr;
	logic       alarm_active;
	modport ctl (output conv_valid, temp, alm_thr, rel_thr, mode_int, shutdown,
		queue_sel, read_clr, input alarm_active);
	modport flt (input conv_valid, temp, alm_thr, rel_thr, mode_int, shutdown,
		queue_sel, read_clr, output alarm_active);
endinterface
`default_nettype wire

// File: hw/tmr_pkg.sv
// Purpose: shared constants, types and decoders of the thermal monitor
// Assumes: one system clock; 9-bit two's complement temperatures
// Notes:   temperature registers hold the 9 live bits only; the 16-bit view is built on read
`default_nettype none
package tmr_pkg;
	// ************************************************************
	// register selection and control field positions
	// ************************************************************
	localparam logic [1:0] SEL_MEAS  = 2'h0;
	localparam logic [1:0] SEL_CTRL  = 2'h1;
	localparam logic [1:0] SEL_REL   = 2'h2;
	localparam logic [1:0] SEL_ALM   = 2'h3;
	localparam int         CTRL_SHDN = 0;
	localparam int         CTRL_MODE = 1;
	localparam int         CTRL_POL  = 2;
	localparam int         CTRL_QLO  = 3;
	localparam int         CTRL_QHI  = 4;
	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [7:0] PTR_RST   = 8'h00;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [8:0] ALM_RST   = 9'h0a0;
	localparam logic [8:0] REL_RST   = 9'h096;
	localparam logic [8:0] MEAS_RST  = 9'h000;
	// ************************************************************
	// bus framing counts, fixed address part and queue depth limit
	// ************************************************************
	localparam logic [3:0] BUS_ID_HI = 4'h9;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] RD_LAST   = 4'h7;
	localparam logic [1:0] WR_IDX_MAX = 2'h3;
	localparam logic [2:0] QMAX      = 3'h6;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR       = 3'b011,
		ST_WR_ACK   = 3'b100,
		ST_RD       = 3'b101,
		ST_RD_ACK   = 3'b110
	} tmr_bus_st_e;

	function automatic logic [2:0] tmr_queue_depth(input logic [1:0] f);
		unique case (f)
			2'h0: tmr_queue_depth = 3'h1;
			2'h1: tmr_queue_depth = 3'h2;
			2'h2: tmr_queue_depth = 3'h4;
			2'h3: tmr_queue_depth = 3'h6;
		endcase
	endfunction

	function automatic logic [15:0] tmr_word(input logic [8:0] v);
		tmr_word = {v, 7'h00};
	endfunction
endpackage
`default_nettype wire

// File: hw/tmr_top.sv
// Purpose: register set of the thermal monitor behind its two-wire pins
// Assumes: converter results arrive on the system clock; pins are asynchronous
// Notes:   alarm and data pins are open drain; oe_n low means pulling low
//
// Operation
// (RQ1) write-only selector picks the accessed register
// (RQ2) selector low bits choose one of four
// (RQ3) host writes zeros to control top bits
// (RQ4) control bit zero set enters shutdown
// (RQ5) control bit one picks comparator or interrupt
// (RQ6) control bit two sets alarm pin polarity
// (RQ7) alarm moves after one, two, four, six agreeing results
// (RQ8) measured value read-only, nine bits at top
// (RQ9) each conversion result loads the measured value
// (RQ10) thresholds read/write, same sixteen-bit layout
// (RQ11) values signed half degrees, signed comparisons
// (RQ12) comparator: set above alarm, clear below release
// (RQ13) interrupt alarm holds until any register read
// (RQ14) shutdown stops conversions; interrupt alarm resets
// (RQ15) comparator alarm held through shutdown
// (RQ16) reset: control zero, thresholds eighty and seventy-five
// (RQ17) selector persists, resets to measured value
`default_nettype none
module tmr_top import tmr_pkg::*; (
	// clock, reset, enable
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clk_en,
	// two-wire bus pins and address straps
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe_n,
	input  wire logic [2:0] i_addr,
	// converter
	input  wire logic       i_conv_valid,
	input  wire logic [8:0] i_conv_temp,
	output logic            o_conv_run,
	// alarm pin
	output logic            o_alarm,
	output logic            o_alarm_oe_n,
	output logic            o_alarm_level
);
	// ************************************************************
	// reset release and pin synchronisers
	// ************************************************************
	logic        rst_meta_r;
	logic        rst_n_r;
	logic        scl_m_r, scl_s_r, scl_d_r;
	logic        sda_m_r, sda_s_r, sda_d_r;
	logic [2:0]  addr_m_r, addr_s_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// the bus idles high, so the chain resets high to avoid a false start
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
			addr_m_r <= 3'h0;
			addr_s_r <= 3'h0;
		end else if (i_clk_en) begin
			{scl_m_r, scl_s_r, scl_d_r} <= {i_scl, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {i_sda, sda_m_r, sda_s_r};
			addr_m_r <= i_addr;
			addr_s_r <= addr_m_r;
		end
	end

	// ************************************************************
	// bus slave state
	// ************************************************************
	tmr_bus_st_e st_r, st_nxt;
	logic [3:0]  bit_cnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  tx_r;
	logic [7:0]  lo_hold_r;
	logic        rw_r;
	logic        nack_r;
	logic        rd_hi_r;
	logic [1:0]  wr_idx_r;
	logic        sda_oe_n_r, sda_oe_n_nxt;
	// ************************************************************
	// register set
	// ************************************************************
	logic [7:0]  ptr_r;
	logic [7:0]  cfg_r;
	logic [7:0]  msb_r;
	logic [8:0]  meas_r;
	logic [8:0]  alm_r;
	logic [8:0]  rel_r;
	logic        conv_run_r;
	logic        alarm_lvl_r;
	logic        alarm_oe_n_r;
	logic        drive_low_r;

	wire         scl_rise  = scl_s_r & ~scl_d_r;
	wire         scl_fall  = ~scl_s_r & scl_d_r;
	wire         start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire         stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	wire         rx_st     = (st_r == ST_ADDR) | (st_r == ST_WR);
	wire         byte_end  = rx_st & scl_fall & (bit_cnt_r == BYTE_BITS);
	wire         addr_hit  = shift_r[7:1] == {BUS_ID_HI, addr_s_r};
	wire         rd_access = scl_fall & (st_r == ST_ADDR_ACK) & rw_r;
	wire         load_tx   = rd_access | (scl_fall & (st_r == ST_RD_ACK) & ~nack_r);
	wire         tx_shift  = scl_fall & (st_r == ST_RD);
	wire         cnt_clr   = start_det | byte_end | load_tx;
	wire         cnt_inc   = (rx_st & scl_rise) | tx_shift;
	wire         wr_byte   = byte_end & (st_r == ST_WR);
	wire  [1:0]  sel       = ptr_r[1:0];                                     // [RQ2]
	wire         wr_ptr    = wr_byte & (wr_idx_r == 2'h0);                   // [RQ1]
	wire         wr_first  = wr_byte & (wr_idx_r == 2'h1);
	wire         wr_second = wr_byte & (wr_idx_r == 2'h2);
	wire         take      = i_conv_valid & ~cfg_r[CTRL_SHDN];               // [RQ4]
	wire  [8:0]  thr_word  = {msb_r, shift_r[7]};
	// control reads back on both bytes, so a two-byte read stays harmless
	wire  [15:0] rd_word   = (sel == SEL_MEAS) ? tmr_word(meas_r) :          // [RQ2] [RQ8]
	                         (sel == SEL_CTRL) ? {cfg_r, cfg_r} :
	                         (sel == SEL_REL)  ? tmr_word(rel_r) : tmr_word(alm_r); // [RQ10]
	wire  [7:0]  tx_load   = rd_hi_r ? rd_word[15:8] : lo_hold_r;

	always_comb begin
		st_nxt = st_r;
		if (start_det) st_nxt = ST_ADDR;
		else if (stop_det) st_nxt = ST_IDLE;
		else begin
			unique case (st_r)
				ST_IDLE:     st_nxt = ST_IDLE;
				ST_ADDR:     if (byte_end) st_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE;
				ST_ADDR_ACK: if (scl_fall) st_nxt = rw_r ? ST_RD : ST_WR;
				ST_WR:       if (byte_end) st_nxt = ST_WR_ACK;
				ST_WR_ACK:   if (scl_fall) st_nxt = ST_WR;
				ST_RD:       if (tx_shift && bit_cnt_r == RD_LAST) st_nxt = ST_RD_ACK;
				ST_RD_ACK:   if (scl_fall) st_nxt = nack_r ? ST_IDLE : ST_RD;
				default:     st_nxt = ST_IDLE;
			endcase
		end
	end

	always_comb begin
		sda_oe_n_nxt = sda_oe_n_r;
		if (start_det | stop_det) sda_oe_n_nxt = 1'b1;
		else if (load_tx) sda_oe_n_nxt = tx_load[7];
		else if (scl_fall & ((st_r == ST_ADDR_ACK) | (st_r == ST_WR_ACK))) sda_oe_n_nxt = 1'b1;
		else if (tx_shift) sda_oe_n_nxt = (bit_cnt_r == RD_LAST) ? 1'b1 : tx_r[6];
		else if (byte_end & ((st_r == ST_WR) | addr_hit)) sda_oe_n_nxt = 1'b0;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r       <= ST_IDLE;
			bit_cnt_r  <= 4'h0;
			shift_r    <= 8'h00;
			sda_oe_n_r <= 1'b1;
			rw_r       <= 1'b0;
			nack_r     <= 1'b1;
		end else if (i_clk_en) begin
			st_r       <= st_nxt;
			bit_cnt_r  <= cnt_clr ? 4'h0 : cnt_inc ? bit_cnt_r + 4'h1 : bit_cnt_r;
			if (rx_st & scl_rise) shift_r <= {shift_r[6:0], sda_s_r};
			sda_oe_n_r <= sda_oe_n_nxt;
			if (byte_end & (st_r == ST_ADDR)) rw_r <= shift_r[0];
			if (scl_rise & (st_r == ST_RD_ACK)) nack_r <= sda_s_r;
		end
	end

	// a two-byte read is snapshotted so a conversion cannot tear it
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_r      <= 8'h00;
			lo_hold_r <= 8'h00;
			rd_hi_r   <= 1'b1;
			wr_idx_r  <= 2'h0;
		end else if (i_clk_en) begin
			if (load_tx) tx_r <= tx_load;
			else if (tx_shift) tx_r <= {tx_r[6:0], 1'b0};
			if (load_tx & rd_hi_r) lo_hold_r <= rd_word[7:0];
			if (start_det) rd_hi_r <= 1'b1;
			else if (load_tx) rd_hi_r <= ~rd_hi_r;
			if (start_det) wr_idx_r <= 2'h0;
			else if (wr_byte && wr_idx_r != WR_IDX_MAX) wr_idx_r <= wr_idx_r + 2'h1;
		end
	end

	// ************************************************************
	// register writes and conversion load
	// ************************************************************
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ptr_r  <= PTR_RST;                                          // [RQ17]
			cfg_r  <= CTRL_RST;                                         // [RQ16]
			msb_r  <= 8'h00;
			meas_r <= MEAS_RST;
			alm_r  <= ALM_RST;                                          // [RQ16]
			rel_r  <= REL_RST;                                          // [RQ16]
		end else if (i_clk_en) begin
			if (wr_ptr) ptr_r <= shift_r;                               // [RQ1] [RQ17]
			if (wr_first && sel == SEL_CTRL) cfg_r <= shift_r;          // [RQ3]
			if (wr_first) msb_r <= shift_r;
			if (wr_second && sel == SEL_ALM) alm_r <= thr_word;         // [RQ10]
			if (wr_second && sel == SEL_REL) rel_r <= thr_word;         // [RQ10]
			if (take) meas_r <= i_conv_temp;                            // [RQ9]
		end
	end

	// ************************************************************
	// alarm filter and pins
	// ************************************************************
	tmr_alarm_if al ();
	assign al.conv_valid = i_conv_valid;
	assign al.temp       = i_conv_temp;
	assign al.alm_thr    = alm_r;
	assign al.rel_thr    = rel_r;
	assign al.mode_int   = cfg_r[CTRL_MODE];                                 // [RQ5]
	assign al.shutdown   = cfg_r[CTRL_SHDN];                                 // [RQ4]
	assign al.queue_sel  = cfg_r[CTRL_QHI:CTRL_QLO];                         // [RQ7]
	assign al.read_clr   = rd_access;                                        // [RQ13]

	tmr_alarm u_alarm (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n_r),
		.i_clk_en  (i_clk_en),
		.al        (al)
	);

	wire pin_lvl = cfg_r[CTRL_POL] ? al.alarm_active : ~al.alarm_active;     // [RQ6]

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			conv_run_r   <= 1'b0;
			alarm_lvl_r  <= 1'b1;
			alarm_oe_n_r <= 1'b1;
			drive_low_r  <= 1'b0;
		end else if (i_clk_en) begin
			conv_run_r   <= ~cfg_r[CTRL_SHDN];                               // [RQ4]
			alarm_lvl_r  <= pin_lvl;
			alarm_oe_n_r <= pin_lvl;
			drive_low_r  <= 1'b0;
		end
	end

	assign o_sda         = drive_low_r;
	assign o_sda_oe_n    = sda_oe_n_r;
	assign o_conv_run    = conv_run_r;
	assign o_alarm       = drive_low_r;
	assign o_alarm_oe_n  = alarm_oe_n_r;
	assign o_alarm_level = alarm_lvl_r;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!rst_n_r);

	a_ptr_persist:  assert property (i_clk_en && !wr_ptr |=> $stable(ptr_r)) // [RQ17]
		else $error("selector changed without a selector write");
	a_sel_decode:   assert property (sel == SEL_CTRL |-> rd_word[15:8] == cfg_r) // [RQ2]
		else $error("control not selected by code one");
	a_meas_load:    assert property (i_clk_en && take |=> meas_r == $past(i_conv_temp)) // [RQ9]
		else $error("conversion result not loaded");
	a_meas_frozen:  assert property (i_clk_en && cfg_r[CTRL_SHDN] |=> $stable(meas_r)) // [RQ14]
		else $error("measured value changed in shutdown");
	a_word_layout:  assert property (sel != SEL_CTRL |-> rd_word[6:0] == 7'h00) // [RQ8]
		else $error("low bits of temperature word not zero");
	a_thr_commit:   assert property (i_clk_en && wr_second && sel == SEL_ALM // [RQ10]
		|=> alm_r == {$past(msb_r), $past(shift_r[7])})
		else $error("alarm threshold write not committed");
	a_pin_polar:    assert property (i_clk_en |=> o_alarm_level == // [RQ6]
		($past(cfg_r[CTRL_POL]) ? $past(al.alarm_active) : !$past(al.alarm_active)))
		else $error("alarm pin polarity wrong");
	a_reset_vals:   assert property ($rose(rst_n_r) |-> cfg_r == CTRL_RST // [RQ16]
		&& alm_r == ALM_RST && rel_r == REL_RST && ptr_r == PTR_RST)
		else $error("register reset values wrong");
	a_run_follow:   assert property (i_clk_en // [RQ4]
		|=> o_conv_run == !$past(cfg_r[CTRL_SHDN]))
		else $error("converter run flag does not follow shutdown bit");
	a_ptr_write:    assert property (i_clk_en && wr_ptr |=> ptr_r == $past(shift_r)) // [RQ1]
		else $error("selector write not taken");
	a_ctrl_write:   assert property (i_clk_en && wr_first && sel == SEL_CTRL // [RQ5]
		|=> cfg_r == $past(shift_r))
		else $error("control write not taken");
	a_ctrl_decode:  assert property (i_clk_en && !(wr_first && sel == SEL_CTRL) // [RQ2]
		|=> $stable(cfg_r))
		else $error("control changed without its selector code");
	a_alm_decode:   assert property (i_clk_en && !(wr_second && sel == SEL_ALM) // [RQ2]
		|=> $stable(alm_r))
		else $error("alarm threshold changed without its selector code");
	a_rel_commit:   assert property (i_clk_en && wr_second && sel == SEL_REL // [RQ10]
		|=> rel_r == {$past(msb_r), $past(shift_r[7])})
		else $error("release threshold write not committed");
	a_meas_ro:      assert property (i_clk_en && !take |=> $stable(meas_r)) // [RQ8]
		else $error("measured value changed without a conversion");

	c_addr_ack:     cover property (byte_end && st_r == ST_ADDR && addr_hit);
	c_reg_read:     cover property (rd_access ##[1:300] tx_shift);
	c_shutdown:     cover property ($rose(cfg_r[CTRL_SHDN]));
endmodule // tmr_top
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench of the thermal monitor register set
// Assumes: bus host model on the pins, converter results driven here
// Notes:   alarm pin and data line are resolved with pull-ups
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [6:0] DEV = {4'b1001, 3'b101};

	logic       ref_clk;
	logic       rst_n;
	logic       scl;
	logic       host_sda;
	logic       sda_out;
	logic       sda_oe_n;
	logic [2:0] addr;
	logic       conv_valid;
	logic [8:0] conv_temp;
	logic       conv_run;
	logic       alarm_out;
	logic       alarm_oe_n;
	logic       alarm_level;
	logic       ok;
	logic [15:0] d;
	int         miscompares;
	int         tests_run;
	logic [8:0] temps [4] = '{9'h1ff, 9'h033, 9'h000, 9'h1cd};
	logic       lvls [4]  = '{1'b1, 1'b0, 1'b0, 1'b1};
	int         depth [4] = '{1, 2, 4, 6};
	wire        sda_wire  = host_sda & (sda_oe_n ? 1'b1 : sda_out);
	wire        alarm_pin = alarm_oe_n ? 1'b1 : alarm_out;

	tmr_top u_tmr_top (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_scl(scl),
		.i_sda(sda_wire), .o_sda(sda_out), .o_sda_oe_n(sda_oe_n), .i_addr(addr),
		.i_conv_valid(conv_valid), .i_conv_temp(conv_temp), .o_conv_run(conv_run),
		.o_alarm(alarm_out), .o_alarm_oe_n(alarm_oe_n), .o_alarm_level(alarm_level));
	tmr_host u_tmr_host (.i_ref_clk(ref_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(host_sda));

	always #5 ref_clk = ~ref_clk;

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic pin(input logic exp, input string what);
		chk({15'h0, alarm_pin}, {15'h0, exp}, what);
		chk({15'h0, alarm_level}, {15'h0, exp}, what);
	endtask

	// result line is inverted outside the pulse so a stale value is never read
	task automatic conv(input logic [8:0] t);
		@(posedge ref_clk);
		conv_valid <= 1'b1;
		conv_temp <= t;
		@(posedge ref_clk);
		conv_valid <= 1'b0;
		conv_temp <= ~t;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic put(input logic [7:0] sel, input logic [15:0] v, input int n);
		u_tmr_host.wr(DEV, sel, v, n, ok);
		chk({15'h0, ok}, 16'h1, "write acknowledge");
	endtask

	task automatic get(input logic [7:0] sel, input logic [15:0] exp, input string what);
		put(sel, 16'h0000, 0);
		u_tmr_host.rd(DEV, d, ok);
		chk(d, exp, what);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		$display("wrong value at %0t: run did not finish", $time);
		wrap_up;
	end

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		conv_valid = 1'b0;
		conv_temp = 9'h000;
		addr = 3'h5;
		miscompares = 0;
		tests_run = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		pin(1'b1, "alarm after reset");
		chk({15'h0, conv_run}, 16'h1, "run after reset");
		u_tmr_host.rd(DEV, d, ok);
		chk(d, 16'h0000, "measured at reset");
		get(8'h01, 16'h0000, "control reset");
		get(8'h03, 16'h5000, "alarm thr reset");
		get(8'h02, 16'h4b00, "release thr reset");
		// a foreign address must be ignored altogether
		u_tmr_host.wr({4'b1001, 3'h2}, 8'h01, 16'h0700, 1, ok);
		chk({15'h0, ok}, 16'h0, "foreign address acked");
		get(8'h01, 16'h0000, "control after foreign write");
		put(8'h03, 16'h197f, 2);
		get(8'h03, 16'h1900, "alarm thr");
		put(8'h02, 16'he77f, 2);
		get(8'h02, 16'he700, "release thr");
		put(8'h00, 16'h1234, 2);
		get(8'h00, 16'h0000, "measured written");
		for (int i = 0; i < 4; i++) begin
			conv(temps[i]);
			pin(lvls[i], "comparator");
		end
		u_tmr_host.rd(DEV, d, ok);
		chk(d, 16'he680, "measured result");
		for (int q = 0; q < 4; q++) begin
			put(8'h01, {3'b000, 2'(q), 3'b000, 8'h00}, 1);
			get(8'h01, {2{3'b000, 2'(q), 3'b000}}, "control");
			repeat (6) conv(9'h1b0);
			pin(1'b1, "queue cold");
			repeat (depth[q] - 1) conv(9'h040);
			pin(1'b1, "queue short");
			conv(9'h040);
			pin(1'b0, "queue full");
		end
		put(8'h01, 16'h0400, 1);
		pin(1'b1, "active high");
		conv(9'h1b0);
		pin(1'b0, "high idle");
		put(8'h01, 16'h0200, 1);
		conv(9'h040);
		pin(1'b0, "interrupt set");
		repeat (2) conv(9'h1b0);
		pin(1'b0, "interrupt held");
		u_tmr_host.rd(DEV, d, ok);
		pin(1'b1, "interrupt cleared");
		conv(9'h040);
		pin(1'b0, "interrupt again");
		put(8'h01, 16'h0300, 1);
		pin(1'b1, "shutdown clears");
		chk({15'h0, conv_run}, 16'h0, "run in shutdown");
		conv(9'h0aa);
		get(8'h00, 16'h2000, "shutdown result");
		put(8'h01, 16'h0000, 1);
		conv(9'h040);
		pin(1'b0, "comparator set");
		put(8'h01, 16'h0100, 1);
		conv(9'h1b0);
		get(8'h00, 16'h2000, "held measured");
		pin(1'b0, "comparator held");
		wrap_up;
	end
endmodule // tb_top
`default_nettype wire

// File: verification/tmr_host.sv
// Purpose: two-wire bus host model that drives the thermal monitor pins
// Assumes: open-drain data line with a pull-up, resolved by the bench
// Notes:   one bit takes 16 system clocks, 8 low then 8 high; clock idles high
`default_nettype none
module tmr_host (
	// system clock
	input  wire logic i_ref_clk,
	// bus pins
	input  wire logic i_sda,
	output var logic  o_scl,
	output var logic  o_sda
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// ************************************************************
	// bit level
	// ************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	// data only moves while the clock is low, so start and stop stay unique
	task automatic start_c();
		o_scl <= 1'b0;
		tick(4);
		o_sda <= 1'b1;
		tick(4);
		o_scl <= 1'b1;
		tick(8);
		o_sda <= 1'b0;
		tick(8);
	endtask

	task automatic stop_c();
		o_scl <= 1'b0;
		tick(4);
		o_sda <= 1'b0;
		tick(4);
		o_scl <= 1'b1;
		tick(8);
		o_sda <= 1'b1;
		tick(16);
	endtask

	// sampled mid high phase, well after the device moves its bit
	task automatic bit_x(input logic b, output logic r);
		o_scl <= 1'b0;
		tick(4);
		o_sda <= b;
		tick(4);
		o_scl <= 1'b1;
		tick(4);
		r = i_sda;
		tick(4);
	endtask

	task automatic xbyte(input logic [7:0] d, output logic [7:0] q, input logic a,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(a, ack);
	endtask

	// ************************************************************
	// register access
	// ************************************************************
	task automatic wr(input logic [6:0] dev, input logic [7:0] sel, input logic [15:0] val,
		input int n, output logic ok);
		logic [7:0]  q;
		logic        a;
		logic [15:0] v;
		v = (sel[1:0] == 2'h1) ? {3'b000, val[12:0]} : val;
		start_c();
		xbyte({dev, 1'b0}, q, 1'b1, a);
		ok = ~a;
		if (ok) begin
			xbyte(sel, q, 1'b1, a);
			ok = ok & ~a;
			for (int k = 0; k < n; k++) begin
				xbyte(v[15 - 8 * k -: 8], q, 1'b1, a);
				ok = ok & ~a;
			end
		end
		stop_c();
	endtask

	// high byte acked by the host, low byte refused to end the read
	task automatic rd(input logic [6:0] dev, output logic [15:0] d, output logic ok);
		logic [7:0] h;
		logic [7:0] l;
		logic       a;
		start_c();
		xbyte({dev, 1'b1}, h, 1'b1, a);
		ok = ~a;
		xbyte(8'hff, h, 1'b0, a);
		xbyte(8'hff, l, 1'b1, a);
		d = {h, l};
		stop_c();
	endtask
endmodule // tmr_host
`default_nettype wire
